// [hiis_defines.svh]
/*
 holds offsets, field positions and codes of the interface identifier block.
 assumes a 32-bit apb register bus with byte addresses.
*/
`ifndef HIIS_DEFINES_SVH
`define HIIS_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define HIIS_OFF_IDENT 12'h030
`define HIIS_OFF_LOC_STRIDE 12'h000
`define HIIS_OFF_CTRL 12'h034
`define HIIS_OFF_STAT 12'h038

// ---------------------------------------------------------------
// field positions of the identifier word
// ---------------------------------------------------------------
`define HIIS_KIND_LSB 0
`define HIIS_KIND_MSB 3
`define HIIS_REV_LSB 4
`define HIIS_REV_MSB 7
`define HIIS_MLOC_BIT 8
`define HIIS_QCAP_BIT 13
`define HIIS_CCAP_BIT 14
`define HIIS_SEL_LSB 17
`define HIIS_SEL_MSB 18
`define HIIS_LOCK_BIT 19

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define HIIS_SEL_QUEUE 2'h0
`define HIIS_SEL_CMDBUF 2'h1
`define HIIS_KIND_QUEUE 4'h0
`define HIIS_KIND_CMDBUF 4'h1
`define HIIS_KIND_LEGACY 4'hF
`define HIIS_REV_QUEUE 4'h0
`define HIIS_REV_CMDBUF 4'h1

`endif

// [hiis_pkg.sv]
/*
 holds the types of the interface identifier block.
 assumes hiis_defines.svh for numeric values.
*/
package hiis_pkg;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      HIIS_SEL_Q = 2'h0,
      HIIS_SEL_C = 2'h1,
      HIIS_SEL_R2 = 2'h2,
      HIIS_SEL_R3 = 2'h3
   } hiis_sel_t;

   typedef struct packed {
      logic [3:0] kind;
      logic [3:0] rev;
   } hiis_active_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic write;
      logic sel;
   } hiis_req_t;

   typedef enum logic [1:0] {
      HIIS_ST_RUN = 2'b01,
      HIIS_ST_INIT = 2'b10
   } hiis_state_t;

endpackage

// [hiis_init_sync.sv]
/*
 holds the synchroniser and edge detector of the module init event pin.
 assumes an asynchronous pin; three flops, change counted when stages two and three agree.
*/
module hiis_init_sync
   import hiis_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic pin,
   output logic pulse
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;
   logic lvl_next;

   // level follows pin only when stages two and three agree
   assign lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;

   // ---------------------------------------------------------------
   // synchroniser chain
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         lvl_reg <= 1'b0;
         pulse <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
         pulse <= lvl_next & ~lvl_reg; // rising edge of the event
      end
   end

endmodule // hiis_init_sync

// [hiis_ident.sv]
/*
 holds the interface identifier and selection register bank with its apb slave.
 assumes a 125 MHz core_clk, rstn as the power-on reset and an asynchronous module init pin.
*/
// What this block does
// RULE_01: choice write is pending until init event
// RULE_02: locked choice ignores all writes
// RULE_03: choice changes only both capable, unlocked
// RULE_04: from queue kind, 01 selects command buffer
// RULE_05: from buffer kind, 00 selects queue
// RULE_06: legacy kind discards all choice writes
// RULE_07: active kind encodes queue, buffer, legacy
// RULE_08: software writes to active kind ignored
// RULE_09: current definition never reports legacy kind
// RULE_10: legacy kind leaves other fields invalid
// RULE_11: revision follows active kind
// RULE_12: locality bit shows five-locality support
// RULE_13: single locality still full protocol, no takeover
// RULE_14: buffer capability bit read-only
// RULE_15: queue capability bit read-only
// RULE_16: reserved bits read zero
// RULE_17: lock sets on one, ignores zero
// RULE_18: init event clears the lock
// RULE_19: only one interface kind active
// RULE_20: active kind governs whole address range
// RULE_21: identical contents at every locality alias
// RULE_22: pending store loads active at init
`include "hiis_defines.svh"
module hiis_ident
   import hiis_pkg::*;
#(
   parameter logic QUEUE_CAP = 1'b1,
   parameter logic CMDBUF_CAP = 1'b1,
   parameter logic MULTI_LOC = 1'b1,
   parameter logic [1:0] BOOT_SEL = 2'h0,
   parameter int LOC_COUNT = 5,
   parameter logic [11:0] LOC_STRIDE = 12'h100,
   parameter logic [11:0] LOC_BASE = 12'h000
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic init_pin,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic queue_iface_active,
   output logic cmd_buffer_active,
   output logic takeover_enable,
   output logic [3:0] active_iface_kind,
   output logic choice_lock
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   hiis_active_t act_reg;
   hiis_active_t act_next;
   logic [1:0] pend_reg;
   logic [1:0] pend_next;
   logic lock_reg;
   logic lock_next;
   logic init_pulse;
   logic init_seen_reg;
   hiis_state_t state_reg;
   hiis_state_t state_next;
   hiis_req_t req;

   // ---------------------------------------------------------------
   // module init event
   // ---------------------------------------------------------------
   hiis_init_sync u_init_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin(init_pin),
      .pulse(init_pulse)
   );

   // ---------------------------------------------------------------
   // apb request decode
   // ---------------------------------------------------------------
   assign req.addr = paddr;
   assign req.wdata = pwdata;
   assign req.write = pwrite;
   assign req.sel = psel & penable & ~pready;

   // alias match: any locality window's identifier offset hits
   logic [LOC_COUNT-1:0] alias_hit;
   genvar gi;
   generate
      for (gi = 0; gi < LOC_COUNT; gi = gi + 1) begin : g_alias
         assign alias_hit[gi] = (req.addr == 12'(LOC_BASE + LOC_STRIDE * gi
            + `HIIS_OFF_IDENT)); // RULE_21
      end
   endgenerate

   wire hit_ident = |alias_hit;
   wire hit_ctrl = (req.addr == `HIIS_OFF_CTRL);
   wire hit_stat = (req.addr == `HIIS_OFF_STAT);
   wire hit_any = hit_ident | hit_ctrl | hit_stat;
   wire wr_ident = req.sel & req.write & hit_ident & pstrb[2];

   // ---------------------------------------------------------------
   // write qualification for choice and lock
   // ---------------------------------------------------------------
   wire both_cap = QUEUE_CAP & CMDBUF_CAP; // RULE_03
   wire [1:0] wsel = req.wdata[`HIIS_SEL_MSB:`HIIS_SEL_LSB];
   wire wlock = req.wdata[`HIIS_LOCK_BIT];
   wire kind_legacy = (act_reg.kind == `HIIS_KIND_LEGACY);
   wire kind_queue = (act_reg.kind == `HIIS_KIND_QUEUE);
   wire kind_cmdbuf = (act_reg.kind == `HIIS_KIND_CMDBUF);
   // only the two defined codes are accepted; redundant code for the
   // running kind is ignored, which also drops 11 from buffer kind
   wire sel_code_ok = (kind_queue & (wsel == `HIIS_SEL_CMDBUF)) // RULE_04
      | (kind_cmdbuf & (wsel == `HIIS_SEL_QUEUE)); // RULE_05
   wire sel_wr_ok = wr_ident & both_cap & ~lock_reg // RULE_02 RULE_03
      & ~kind_legacy & sel_code_ok; // RULE_06 RULE_01
   wire lock_wr_ok = wr_ident & both_cap & wlock; // RULE_17
   // right after reset the pending store is not loaded yet: the boot choice stands in
   wire [1:0] pend_eff = init_seen_reg ? pend_reg : BOOT_SEL; // RULE_22

   // ---------------------------------------------------------------
   // next state of choice, lock and active kind
   // ---------------------------------------------------------------
   always_comb begin
      pend_next = pend_reg;
      lock_next = lock_reg;
      act_next = act_reg;
      state_next = state_reg;
      case (state_reg)
         HIIS_ST_RUN: begin
            if (sel_wr_ok) begin
               pend_next = wsel; // RULE_01 RULE_22
            end
            if (lock_wr_ok) begin
               lock_next = 1'b1; // RULE_17
            end
            if (init_pulse) begin
               state_next = HIIS_ST_INIT;
            end
         end
         HIIS_ST_INIT: begin
            // apply pending choice; active kind never becomes legacy
            lock_next = 1'b0; // RULE_18
            // a write landing in the init cycle is kept; a lock set wins over the clear
            if (sel_wr_ok) begin
               pend_next = wsel; // RULE_01
            end
            if (lock_wr_ok) begin
               lock_next = 1'b1; // RULE_17
            end
            if (pend_eff == `HIIS_SEL_CMDBUF && CMDBUF_CAP) begin
               act_next.kind = `HIIS_KIND_CMDBUF; // RULE_22 RULE_09
               act_next.rev = `HIIS_REV_CMDBUF; // RULE_11
            end else begin
               act_next.kind = `HIIS_KIND_QUEUE; // RULE_22 RULE_09
               act_next.rev = `HIIS_REV_QUEUE; // RULE_11
            end
            state_next = HIIS_ST_RUN;
         end
         default: begin
            state_next = HIIS_ST_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pend_reg <= `HIIS_SEL_QUEUE;
         lock_reg <= 1'b0;
         act_reg <= '{kind: `HIIS_KIND_QUEUE, rev: `HIIS_REV_QUEUE};
         state_reg <= HIIS_ST_INIT;
         init_seen_reg <= 1'b0;
      end else begin
         pend_reg <= (init_seen_reg) ? pend_next : BOOT_SEL; // boot choice
         lock_reg <= lock_next;
         act_reg <= act_next; // RULE_08
         state_reg <= state_next;
         init_seen_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // read data assembly
   // ---------------------------------------------------------------
   logic [31:0] ident_word;
   always_comb begin
      ident_word = 32'h0000_0000; // RULE_16
      ident_word[`HIIS_KIND_MSB:`HIIS_KIND_LSB] = act_reg.kind; // RULE_07
      ident_word[`HIIS_REV_MSB:`HIIS_REV_LSB] = act_reg.rev; // RULE_11
      ident_word[`HIIS_MLOC_BIT] = MULTI_LOC; // RULE_12
      ident_word[`HIIS_QCAP_BIT] = QUEUE_CAP; // RULE_15
      ident_word[`HIIS_CCAP_BIT] = CMDBUF_CAP; // RULE_14
      ident_word[`HIIS_SEL_MSB:`HIIS_SEL_LSB] = pend_reg;
      ident_word[`HIIS_LOCK_BIT] = lock_reg; // RULE_17
      if (kind_legacy) begin
         ident_word = {28'h0000000, act_reg.kind}; // RULE_10
      end
   end

   wire [31:0] stat_word = {26'h0, state_reg, kind_cmdbuf, kind_queue, lock_reg, 1'b0};
   wire [31:0] rd_word = hit_ident ? ident_word :
      hit_stat ? stat_word : 32'h0000_0000;

   // ---------------------------------------------------------------
   // apb answer and outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= req.sel; // one wait state
         prdata <= (req.sel & ~req.write) ? rd_word : 32'h0000_0000;
         pslverr <= req.sel & ~hit_any;
      end
   end

   // the active kind steers exactly one whole-range decoder
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         queue_iface_active <= 1'b0;
         cmd_buffer_active <= 1'b0;
         takeover_enable <= 1'b0;
         active_iface_kind <= `HIIS_KIND_QUEUE;
         choice_lock <= 1'b0;
      end else begin
         queue_iface_active <= (act_next.kind == `HIIS_KIND_QUEUE); // RULE_19 RULE_20
         cmd_buffer_active <= (act_next.kind == `HIIS_KIND_CMDBUF); // RULE_19 RULE_20
         takeover_enable <= MULTI_LOC; // RULE_13
         active_iface_kind <= act_next.kind;
         choice_lock <= lock_next;
      end
   end

endmodule // hiis_ident

// [hiis_ident_assertions.sv]
/*
 checker of the identifier bank, watching only the ports of hiis_ident.
 assumes the default map: five identifier aliases at 0x030 + 0x100 * n.
*/
module hiis_ident_assertions
   import hiis_pkg::*;
#(
   parameter logic QUEUE_CAP = 1'b1,
   parameter logic CMDBUF_CAP = 1'b1,
   parameter logic MULTI_LOC = 1'b1
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic init_pin,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic queue_iface_active,
   input wire logic cmd_buffer_active,
   input wire logic takeover_enable,
   input wire logic [3:0] active_iface_kind,
   input wire logic choice_lock
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // answer cycle of a read of any identifier alias
   wire logic rd_id = pready && !pwrite && paddr[7:0] == 8'h30 && paddr[11:8] < 4'h5;
   wire logic wr_lock = psel && penable && pwrite && pstrb[2] && pwdata[19];
   logic [3:0] since_init;
   // cycles since the init pin was last high, saturating
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) since_init <= 4'hF;
      else if (init_pin) since_init <= 4'h0;
      else if (since_init != 4'hF) since_init <= since_init + 4'h1;
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_one_kind_active: assert property ($past(rstn, 2) |->
      queue_iface_active ^ cmd_buffer_active)
      else $error("not exactly one interface kind active");
   a_kind_from_active: assert property ($past(rstn, 2) |->
      active_iface_kind == {3'h0, cmd_buffer_active})
      else $error("active kind does not match active interface");
   a_kind_not_legacy: assert property (active_iface_kind != 4'hF)
      else $error("legacy kind reported");
   a_kind_only_init: assert property ($changed(active_iface_kind) |->
      since_init < 4'hE)
      else $error("active kind changed without init event");
   a_lock_clear_init: assert property ($fell(choice_lock) |-> since_init < 4'hE)
      else $error("lock cleared without init event");
   a_lock_set_write: assert property ($rose(choice_lock) |->
      $past(wr_lock) || $past(wr_lock, 2))
      else $error("lock set without a write of one");
   a_ready_after_take: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready not a single pulse after take");
   a_reserved_zero: assert property (pready && !pwrite |->
      prdata[16:15] == 2'h0 && prdata[12:9] == 4'h0)
      else $error("reserved bits not zero");
   a_caps_read: assert property (rd_id |->
      prdata[14:13] == {CMDBUF_CAP, QUEUE_CAP} && prdata[8] == MULTI_LOC)
      else $error("capability bits wrong");
   a_rev_lock_read: assert property (rd_id |->
      prdata[7:0] == {3'h0, cmd_buffer_active, active_iface_kind} && prdata[19] == choice_lock)
      else $error("revision, kind or lock read wrong");
   a_takeover_fixed: assert property ($past(rstn, 2) |->
      takeover_enable == MULTI_LOC)
      else $error("takeover enable wrong");
   c_lock_set: cover property ($rose(choice_lock));
   c_kind_buffer: cover property ($rose(cmd_buffer_active));
   c_alias_read: cover property (rd_id && paddr[11:8] == 4'h4);
endmodule // hiis_ident_assertions

bind hiis_ident hiis_ident_assertions #(.QUEUE_CAP(QUEUE_CAP), .CMDBUF_CAP(CMDBUF_CAP),
   .MULTI_LOC(MULTI_LOC)) hiis_ident_assertions_i (.core_clk(core_clk), .rstn(rstn),
   .init_pin(init_pin), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .queue_iface_active(queue_iface_active), .cmd_buffer_active(cmd_buffer_active),
   .takeover_enable(takeover_enable), .active_iface_kind(active_iface_kind),
   .choice_lock(choice_lock));

// [hiis_ident_test.sv]
/*
 self-checking bench of the identifier bank: apb accesses, init events, random writes.
 assumes default parameters of hiis_ident (both interfaces capable, five localities).
*/
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module hiis_ident_test
   import hiis_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rstn = 0, init_pin = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, r, d, seed = 32'd89809;
   logic [3:0] pstrb = 0, active_iface_kind, m_kind = 0;
   logic [31:0] prdata;
   logic pready, pslverr, queue_iface_active, cmd_buffer_active, takeover_enable, choice_lock;
   logic [1:0] m_pend = 0;
   logic m_lock = 0;
   int errors = 0, n_checks = 0, cyc = 0;
   hiis_ident hiis_ident_i (.core_clk(core_clk), .rstn(rstn), .init_pin(init_pin), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .queue_iface_active(queue_iface_active), .cmd_buffer_active(cmd_buffer_active),
      .takeover_enable(takeover_enable), .active_iface_kind(active_iface_kind),
      .choice_lock(choice_lock));
   // ----------------------------------------
   // clock, timeout, helpers
   // ----------------------------------------
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected identifier word from the bench's own state
   function automatic logic [31:0] exp_id();
      return {12'h000, m_lock, m_pend, 4'h3, 4'h0, 1'b1, m_kind, m_kind};
   endfunction
   // one apb transfer; request held until the rising edge at which ready is high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                      input logic [3:0] s);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dd;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // write with the bench's model of which choice and lock writes count
   task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
      apb(1'b1, a, dd, s);
      if (s[2] && !m_lock && dd[18:17] == (m_kind == 4'h0 ? 2'h1 : 2'h0)) m_pend = dd[18:17];
      if (s[2] && dd[19]) m_lock = 1'b1;
   endtask
   task automatic chk_id(input logic [11:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
      `CHK(rd, exp_id())
      `CHK({er, choice_lock, active_iface_kind, cmd_buffer_active, queue_iface_active},
         {1'b0, m_lock, m_kind, m_kind[0], ~m_kind[0]})
      `CHK(takeover_enable, 1'b1)
   endtask
   task automatic init_ev();
      @(posedge core_clk);
      init_pin <= 1'b1;
      repeat (12) @(posedge core_clk);
      init_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      m_lock = 1'b0;
      m_kind = {3'h0, m_pend == 2'h1};
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int n = 0; n < 5; n++) chk_id(12'h030 + 12'(n) * 12'h100);
      apb(1'b0, 12'h0FC, 32'h0, 4'h0);
      `CHK(er, 1'b1)
      $display("test reset contents done");
      wr(12'h030, 32'h0000_0000, 4'hF);
      wr(12'h130, 32'h0004_FFFF, 4'hF);
      wr(12'h230, 32'h0002_0000, 4'hB);
      chk_id(12'h330);
      wr(12'h430, 32'h0002_0000, 4'h4);
      chk_id(12'h030);
      init_ev();
      chk_id(12'h130);
      wr(12'h030, 32'h0006_0000, 4'hF);
      wr(12'h030, 32'h000A_0000, 4'hF);
      wr(12'h030, 32'h0000_0000, 4'hF);
      wr(12'h030, 32'h0002_0000, 4'hF);
      chk_id(12'h230);
      init_ev();
      chk_id(12'h030);
      wr(12'h130, 32'h0000_0000, 4'h4);
      init_ev();
      chk_id(12'h430);
      $display("test choice and lock done");
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         d = rnd();
         if (r[7:4] != 4'h0) d[19] = 1'b0;
         else d[18:17] = m_pend;
         wr(12'h030 + 12'(r % 32'h5) * 12'h100, d, r[11:8]);
         if (r[15:13] == 3'h0) init_ev();
         chk_id(12'h030 + 12'(rnd() % 32'h5) * 12'h100);
      end
      $display("test random writes done");
      close_out();
   end
endmodule // hiis_ident_test
